// File: src/tes_pkg.sv
// Purpose: Shared constants for the trigger/encoder/sync status bank
// Assumes: Byte-addressed plain register port, 32-bit data
// Notes: Offsets chosen per one aligned word per register
package tes_pkg;
  // Register byte offsets
  localparam logic [3:0] TES_CTRL_OFFSET = 4'h0;
  localparam logic [3:0] TES_STAT_OFFSET = 4'h4;
  // Control register field positions
  localparam int TES_TRIG_SRC_LSB = 0;
  localparam int TES_SOFT_TRIG_BIT = 3;
  localparam int TES_ENC_SRC_LSB = 4;
  localparam int TES_SOFT_ENC_BIT = 7;
  localparam int TES_FRAME_LVL_BIT = 26;
  localparam int TES_SYNC_LSB = 27;
  localparam int TES_EN_TRIG_BIT = 30;
  localparam int TES_EN_ENC_BIT = 31;
  // Status register field positions
  localparam int TES_VLINE_LSB = 0;
  localparam int TES_VLINE_W = 17;
  localparam int TES_LATCH_MODE_BIT = 17;
  localparam int TES_DIV_LSB = 18;
  localparam int TES_DIV_W = 10;
  localparam int TES_HPIX_LSB = 28;
  localparam int TES_TRIG_LVL_BIT = 30;
  // Values after reset
  localparam logic [1:0] TES_SEL_RESET = 2'h0;
  localparam logic [2:0] TES_SYNC_RESET = 3'h0;
  localparam logic [9:0] TES_DIV_RESET = 10'h000;
  // Trigger sources
  localparam logic [1:0] TES_SRC_DIFF = 2'h0;
  localparam logic [1:0] TES_SRC_TTL = 2'h1;
  localparam logic [1:0] TES_SRC_OPTO = 2'h2;
  localparam logic [1:0] TES_SRC_FRAME = 2'h3;
  // Camera-control resync modes
  typedef enum logic [2:0] {
    TES_SYNC_NONE = 3'b000,
    TES_SYNC_PRIMARY = 3'b001,
    TES_SYNC_SECONDARY = 3'b010,
    TES_SYNC_EACH = 3'b011
  } tes_sync_t;
endpackage

// File: src/tes_trigger_encoder_sync_status.sv
// Purpose: Camera-control resync, trigger/encoder gating, encoder divider
//          and counter readback behind a plain register port
// Assumes: Pins and pixel clocks are asynchronous to clk (250 MHz);
//          counters and control lines come from clk-domain logic
// Notes: Pixel clocks are sampled, their rising edges act as enables
`timescale 1ns/1ns
module tes_trigger_encoder_sync_status
  import tes_pkg::*;
#(
  parameter int CTL_W = 4
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic trig_diff_pin,
  input wire logic trig_ttl_pin,
  input wire logic trig_opto_pin,
  input wire logic enc_diff_pin,
  input wire logic enc_ttl_pin,
  input wire logic enc_opto_pin,
  input wire logic camera_frame_valid_input,
  input wire logic pixel_clock_primary,
  input wire logic pixel_clock_secondary,
  input wire logic [16:0] vertical_line_counter,
  input wire logic [1:0] horizontal_pixel_counter,
  input wire logic [CTL_W-1:0] camera_control_line_primary_in,
  input wire logic [CTL_W-1:0] camera_control_line_secondary_in,
  output logic [CTL_W-1:0] camera_control_line_primary,
  output logic [CTL_W-1:0] camera_control_line_secondary,
  output logic trigger_out,
  output logic encoder_pulse,
  output logic [9:0] encoder_ratio_m_param
);

  if (CTL_W < 1 || CTL_W > 16)
  begin : g_bad_width
    $error("CTL_W must be 1..16");
  end

  // Effective divisor: zero and one both mean undivided
  function automatic logic [9:0] eff_div(input logic [9:0] d);
    eff_div = (d < 10'h002) ? 10'h001 : d;
  endfunction

  // Writable fields
  logic [1:0] trigger_source_select;
  logic software_trigger_bit;
  logic [1:0] encoder_source_select;
  logic software_encoder_bit;
  logic [2:0] control_output_sync_code;
  logic ext_trigger_enable;
  logic ext_encoder_enable;
  logic last_line_latch_mode;
  logic [9:0] encoder_pulse_divider;

  // Synchronizers: 0-2 trig, 3-5 enc, 6 frame, 7 pclk p, 8 pclk s
  logic [8:0] sync_a;
  logic [8:0] sync_b;
  logic pclk_p_prev;
  logic pclk_s_prev;
  logic frame_prev;
  logic [16:0] last_line;
  logic enc_level;
  logic enc_prev;
  logic [9:0] enc_count;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_a <= 9'h000;
      sync_b <= 9'h000;
    end
    else
    begin
      sync_a <= {pixel_clock_secondary, pixel_clock_primary,
                 camera_frame_valid_input, enc_opto_pin, enc_ttl_pin,
                 enc_diff_pin, trig_opto_pin, trig_ttl_pin, trig_diff_pin};
      sync_b <= sync_a;
    end
  end

  // Named views of the synchronized inputs
  wire frame_level = sync_b[6];
  wire pclk_p_edge = sync_b[7] & ~pclk_p_prev;
  wire pclk_s_edge = sync_b[8] & ~pclk_s_prev;
  wire frame_fall = frame_prev & ~frame_level;

  // Source selection
  wire selected_trigger_level =
    (trigger_source_select == TES_SRC_DIFF) ? sync_b[0] :
    (trigger_source_select == TES_SRC_TTL) ? sync_b[1] :
    (trigger_source_select == TES_SRC_OPTO) ? sync_b[2] :
    frame_level;
  wire selected_encoder_level =
    (encoder_source_select == TES_SRC_DIFF) ? sync_b[3] :
    (encoder_source_select == TES_SRC_TTL) ? sync_b[4] :
    (encoder_source_select == TES_SRC_OPTO) ? sync_b[5] :
    1'b0; // Reserved source reads low
  wire trig_gated = (ext_trigger_enable & selected_trigger_level)
                    | software_trigger_bit;
  wire enc_gated = (ext_encoder_enable & selected_encoder_level)
                   | software_encoder_bit;

  // Encoder divider decode
  wire enc_rise = enc_level & ~enc_prev;
  wire [9:0] div_n = eff_div(encoder_pulse_divider);
  wire div_hit = (enc_count >= div_n - 10'h001);

  // Resync mode decode; reserved codes fall back to unsynchronized
  wire [2:0] sc = control_output_sync_code;
  wire mode_p = (sc == TES_SYNC_PRIMARY);
  wire mode_s = (sc == TES_SYNC_SECONDARY);
  wire mode_e = (sc == TES_SYNC_EACH);
  wire mode_none = ~(mode_p | mode_s | mode_e);
  wire load_p = mode_none | (mode_p & pclk_p_edge) |
                (mode_s & pclk_s_edge) | (mode_e & pclk_p_edge);
  wire load_s = mode_none | (mode_p & pclk_p_edge) |
                (mode_s & pclk_s_edge) | (mode_e & pclk_s_edge);

  // Register decode and read mux
  wire sel_ctrl = (addr == TES_CTRL_OFFSET);
  wire sel_stat = (addr == TES_STAT_OFFSET);
  wire [16:0] vline_view = last_line_latch_mode ? last_line
                            : vertical_line_counter;
  wire [31:0] ctrl_view = {ext_encoder_enable, ext_trigger_enable,
                           control_output_sync_code, frame_level,
                           18'h00000, software_encoder_bit, 1'b0,
                           encoder_source_select, software_trigger_bit,
                           1'b0, trigger_source_select};
  wire [31:0] stat_view = {1'b0, selected_trigger_level,
                           horizontal_pixel_counter,
                           encoder_pulse_divider, last_line_latch_mode,
                           vline_view};
  wire [31:0] next_rdata = sel_ctrl ? ctrl_view :
                           sel_stat ? stat_view : 32'h00000000;

  // Register writes; everything clears on reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      trigger_source_select <= TES_SEL_RESET;
      software_trigger_bit <= 1'b0;
      encoder_source_select <= TES_SEL_RESET;
      software_encoder_bit <= 1'b0;
      control_output_sync_code <= TES_SYNC_RESET;
      ext_trigger_enable <= 1'b0;
      ext_encoder_enable <= 1'b0;
      last_line_latch_mode <= 1'b0;
      encoder_pulse_divider <= TES_DIV_RESET;
    end
    else if (wr && sel_ctrl)
    begin
      trigger_source_select <= wdata[TES_TRIG_SRC_LSB +: 2];
      software_trigger_bit <= wdata[TES_SOFT_TRIG_BIT];
      encoder_source_select <= wdata[TES_ENC_SRC_LSB +: 2];
      software_encoder_bit <= wdata[TES_SOFT_ENC_BIT];
      control_output_sync_code <= wdata[TES_SYNC_LSB +: 3];
      ext_trigger_enable <= wdata[TES_EN_TRIG_BIT];
      ext_encoder_enable <= wdata[TES_EN_ENC_BIT];
    end
    else if (wr && sel_stat)
    begin
      last_line_latch_mode <= wdata[TES_LATCH_MODE_BIT];
      encoder_pulse_divider <= wdata[TES_DIV_LSB +: TES_DIV_W];
    end
  end

  // Read data, valid the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata <= 32'h00000000;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= 32'h00000000;
  end

  // Edge history and last-active-line latch at frame end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pclk_p_prev <= 1'b0;
      pclk_s_prev <= 1'b0;
      frame_prev <= 1'b0;
      last_line <= 17'h00000;
    end
    else
    begin
      pclk_p_prev <= sync_b[7];
      pclk_s_prev <= sync_b[8];
      frame_prev <= frame_level;
      if (frame_fall)
        last_line <= vertical_line_counter;
    end
  end

  // Camera-control outputs, reloaded on the chosen pixel clock edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      camera_control_line_primary <= '0;
      camera_control_line_secondary <= '0;
    end
    else
    begin
      if (load_p)
        camera_control_line_primary <= camera_control_line_primary_in;
      if (load_s)
        camera_control_line_secondary <= camera_control_line_secondary_in;
    end
  end

  // Trigger output and encoder divider
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      trigger_out <= 1'b0;
      enc_level <= 1'b0;
      enc_prev <= 1'b0;
      enc_count <= 10'h000;
      encoder_pulse <= 1'b0;
      encoder_ratio_m_param <= 10'h000;
    end
    else
    begin
      trigger_out <= trig_gated;
      enc_level <= enc_gated;
      enc_prev <= enc_level;
      encoder_pulse <= enc_rise & div_hit;
      encoder_ratio_m_param <= encoder_pulse_divider;
      if (enc_rise)
        enc_count <= div_hit ? 10'h000 : enc_count + 10'h001;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  frame_read_a: assert property (rd && sel_ctrl |=>
    rdata[TES_FRAME_LVL_BIT] == $past(frame_level))
    else $error("frame level readback wrong");
  unsync_out_a: assert property (mode_none |=>
    camera_control_line_primary == $past(camera_control_line_primary_in))
    else $error("unsynchronized output not passed");
  sync_prim_a: assert property (mode_p && !pclk_p_edge |=>
    $stable(camera_control_line_primary) &&
    $stable(camera_control_line_secondary))
    else $error("output changed off primary edge");
  sync_sec_a: assert property (mode_s && !pclk_s_edge |=>
    $stable(camera_control_line_primary))
    else $error("output changed off secondary edge");
  sync_each_a: assert property (mode_e && pclk_s_edge && !pclk_p_edge |=>
    $stable(camera_control_line_primary) &&
    camera_control_line_secondary == $past(camera_control_line_secondary_in))
    else $error("per-connector resync wrong");
  trig_gate_a: assert property (trigger_out == $past(trig_gated))
    else $error("trigger gating wrong");
  enc_gate_a: assert property (!enc_gated |-> ##2 !encoder_pulse)
    else $error("encoder pulse while gated off");
  div_pass_a: assert property (enc_rise && div_n == 10'h001 |=>
    encoder_pulse)
    else $error("undivided pulse missing");
  div_hold_a: assert property (enc_rise && !div_hit |=>
    !encoder_pulse)
    else $error("divider pulsed early");
  vline_live_a: assert property (rd && sel_stat && !last_line_latch_mode
    |=> rdata[16:0] == $past(vertical_line_counter))
    else $error("live vertical count wrong");
  vline_latch_a: assert property (rd && sel_stat && last_line_latch_mode
    |=> rdata[16:0] == $past(last_line))
    else $error("latched vertical count wrong");
  hpix_read_a: assert property (rd && sel_stat |=>
    rdata[29:28] == $past(horizontal_pixel_counter))
    else $error("horizontal bits wrong");

  divided_c: cover property (enc_rise && div_n > 10'h002 && div_hit);
  sync_each_c: cover property (mode_e && pclk_p_edge ##1 pclk_s_edge);
  latch_c: cover property (frame_fall ##[1:50] rd && sel_stat &&
    last_line_latch_mode);
endmodule

// File: verif/tes_far_side_model.sv
// Purpose: Cameras and external trigger/encoder lines
// Assumes: Pins are asynchronous to the board clock
// Notes: Pixel clocks run only when a test asks, low otherwise
`timescale 1ns/1ns
module tes_far_side_model
(
  output logic [2:0] trig_pin,
  output logic [2:0] enc_pin,
  output logic frame_valid,
  output logic pclk_p,
  output logic pclk_s
);
  logic run_p = 1'b0;
  logic run_s = 1'b0;
  logic [2:0] trig_q = 3'h0;
  logic [2:0] enc_q = 3'h0;
  logic frame_q = 1'b0;
  // Quiet lines at start, one driver each
  assign trig_pin = trig_q;
  assign enc_pin = enc_q;
  assign frame_valid = frame_q;
  // Primary pixel clock, 125 ns, low unless asked to run
  always
  begin
    pclk_p = 1'b0;
    #63;
    pclk_p = run_p;
    #62;
  end
  // Secondary pixel clock, same rate, other phase
  always
  begin
    pclk_s = 1'b0;
    #50;
    pclk_s = run_s;
    #62;
    pclk_s = 1'b0;
    #13;
  end
  // Trigger level; source 3 is the frame-valid line
  task level(input int s, input logic l);
    if (s == 3)
      frame_q = l;
    else
      trig_q[s] = l;
  endtask
  // Train of encoder pulses on one pin
  task enc_pulses(input int s, input int n);
    repeat (n)
    begin
      #40;
      enc_q[s] = 1'b1;
      #40;
      enc_q[s] = 1'b0;
    end
  endtask
  // Run chosen pixel clocks for a while
  task run_clocks(input bit p, input bit q, input int t);
    run_p = p;
    run_s = q;
    #t;
    run_p = 1'b0;
    run_s = 1'b0;
    #130;
  endtask
endmodule

// File: verif/tes_trigger_encoder_sync_status_tb_top.sv
// Purpose: Self-checking bench for the trigger/encoder/sync bank
// Assumes: Register port answers one cycle after a read strobe
// Notes: Pins and pixel clocks come from the far-side model
`timescale 1ns/1ns
module tes_trigger_encoder_sync_status_tb_top
  import tes_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic [2:0] tp;
  logic [2:0] ep;
  logic fv;
  logic pp;
  logic ps;
  logic [16:0] vcnt = 17'h15a5a;
  logic [1:0] hcnt = 2'h0;
  logic [3:0] ci_p = 4'h0;
  logic [3:0] ci_s = 4'h0;
  logic [3:0] co_p;
  logic [3:0] co_s;
  logic [3:0] v = 4'h0;
  logic [3:0] e_p = 4'h0;
  logic [3:0] e_s = 4'h0;
  logic trig_o;
  logic enc_o;
  logic [9:0] m_o;
  int failures = 0;
  int compares = 0;
  int pulses = 0;
  int base = 0;
  // 250 MHz clock
  initial
    forever #2 clk = ~clk;
  // Count divided encoder pulses
  always @(posedge clk)
    if (enc_o === 1'b1)
      pulses <= pulses + 1;
  tes_far_side_model u_tes_far_side_model (.trig_pin(tp), .enc_pin(ep),
    .frame_valid(fv), .pclk_p(pp), .pclk_s(ps));
  tes_trigger_encoder_sync_status u_tes_trigger_encoder_sync_status (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .trig_diff_pin(tp[0]), .trig_ttl_pin(tp[1]),
    .trig_opto_pin(tp[2]), .enc_diff_pin(ep[0]), .enc_ttl_pin(ep[1]),
    .enc_opto_pin(ep[2]), .camera_frame_valid_input(fv),
    .pixel_clock_primary(pp), .pixel_clock_secondary(ps),
    .vertical_line_counter(vcnt), .horizontal_pixel_counter(hcnt),
    .camera_control_line_primary_in(ci_p),
    .camera_control_line_secondary_in(ci_s),
    .camera_control_line_primary(co_p),
    .camera_control_line_secondary(co_s), .trigger_out(trig_o),
    .encoder_pulse(enc_o), .encoder_ratio_m_param(m_o));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask
  // Reset values and an unmapped address
  task t_reset;
    rreg(TES_CTRL_OFFSET);
    chk(rv, 32'h0);
    rreg(TES_STAT_OFFSET);
    chk(rv, {15'h0, vcnt});
    wreg(4'h8, 32'hffffffff);
    rreg(4'h8);
    chk(rv, 32'h0);
    rreg(TES_CTRL_OFFSET);
    chk(rv, 32'h0);
    chk(m_o, 10'h0);
  endtask
  // Live and latched vertical count, horizontal bits
  task t_last_line;
    u_tes_far_side_model.level(3, 1'b1);
    @(posedge clk);
    vcnt <= 17'h0abcd;
    hcnt <= 2'h2;
    cyc(8);
    u_tes_far_side_model.level(3, 1'b0);
    cyc(8);
    @(posedge clk);
    vcnt <= 17'h01234;
    wreg(TES_STAT_OFFSET, 32'h20000);
    rreg(TES_STAT_OFFSET);
    chk(rv, {4'h2, 10'h0, 1'b1, 17'h0abcd});
    wreg(TES_STAT_OFFSET, 32'h0);
    rreg(TES_STAT_OFFSET);
    chk(rv, {4'h2, 10'h0, 1'b0, 17'h01234});
  endtask
  // Each trigger source, gated and raw, then software trigger
  task t_trig;
    logic [31:0] e;
    for (int s = 0; s < 4; s++)
    begin
      e = 32'(s);
      e[26] = (s == 3);
      u_tes_far_side_model.level(s, 1'b1);
      wreg(TES_CTRL_OFFSET, 32'(s));
      cyc(8);
      chk(trig_o, 1'b0);
      rreg(TES_STAT_OFFSET);
      chk(rv[30], 1'b1);
      rreg(TES_CTRL_OFFSET);
      chk(rv, e);
      wreg(TES_CTRL_OFFSET, 32'h40000000 | 32'(s));
      cyc(8);
      chk(trig_o, 1'b1);
      u_tes_far_side_model.level(s, 1'b0);
      cyc(8);
      chk(trig_o, 1'b0);
    end
    wreg(TES_CTRL_OFFSET, 32'h8);
    cyc(4);
    chk(trig_o, 1'b1);
  endtask
  // Encoder sources, divider values, gating, software pulse
  task t_enc;
    for (int s = 0; s < 3; s++)
    begin
      wreg(TES_STAT_OFFSET, 32'h3 << TES_DIV_LSB);
      wreg(TES_CTRL_OFFSET, 32'h80000000 | (32'(s) << 4));
      base = pulses;
      u_tes_far_side_model.enc_pulses(s, 6);
      cyc(10);
      chk(pulses - base, 2);
    end
    chk(m_o, 10'h3);
    for (int d = 0; d < 2; d++)
    begin
      wreg(TES_STAT_OFFSET, 32'(d) << TES_DIV_LSB);
      base = pulses;
      u_tes_far_side_model.enc_pulses(2, 3);
      cyc(10);
      chk(pulses - base, 3);
    end
    wreg(TES_CTRL_OFFSET, 32'h20);
    base = pulses;
    u_tes_far_side_model.enc_pulses(2, 3);
    cyc(10);
    chk(pulses - base, 0);
    // Reserved encoder source reads low even when enabled
    wreg(TES_CTRL_OFFSET, 32'h80000030);
    u_tes_far_side_model.enc_pulses(0, 3);
    cyc(10);
    chk(pulses - base, 0);
    wreg(TES_CTRL_OFFSET, 32'ha0);
    wreg(TES_CTRL_OFFSET, 32'h20);
    cyc(10);
    chk(pulses - base, 1);
  endtask
  // New control values, stopped clocks, then chosen clocks run
  task sync_case(input logic [2:0] c, input bit rp, input bit rs,
    input bit up, input bit us);
    wreg(TES_CTRL_OFFSET, 32'(c) << TES_SYNC_LSB);
    v = v + 4'h1;
    @(posedge clk);
    ci_p <= v;
    ci_s <= ~v;
    if (c == 3'h0 || c > 3'h3)
    begin
      e_p = v;
      e_s = ~v;
    end
    cyc(30);
    chk(co_p, e_p);
    chk(co_s, e_s);
    u_tes_far_side_model.run_clocks(rp, rs, 400);
    if (up)
      e_p = v;
    if (us)
      e_s = ~v;
    cyc(2);
    chk(co_p, e_p);
    chk(co_s, e_s);
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_last_line;
    t_trig;
    t_enc;
    sync_case(TES_SYNC_NONE, 0, 0, 1, 1);
    sync_case(TES_SYNC_PRIMARY, 1, 0, 1, 1);
    sync_case(TES_SYNC_SECONDARY, 1, 0, 0, 0);
    sync_case(TES_SYNC_SECONDARY, 0, 1, 1, 1);
    sync_case(TES_SYNC_EACH, 1, 0, 1, 0);
    sync_case(TES_SYNC_EACH, 0, 1, 0, 1);
    sync_case(3'h5, 0, 0, 1, 1);
    test_done;
  end
  // Cut a hang short
  initial
  begin
    #400000;
    failures++;
    test_done;
  end
endmodule
